// ==== src/rtc_values_pkg.sv ====
// Shared constants of the counter and calendar value block.
// Assumes a single APB clock that also drives the counting logic.
// Functional notes
// - Zero trim magnitude leaves counting rate unchanged.
// - Trim magnitude 1-127 shifts rate proportionally.
// - Trim sign zero speeds up, one slows.
// - Single layout: 32-bit count at 0x10.
// - Period layout: 16-bit count at 0x10.
// - Value registers write-protected, read/write synchronized.
// - Period layout: 16-bit wrap limit at 0x14.
// - Wrap and match write-protected, write-synchronized.
// - Calendar layout: packed date word at 0x10.
// - Bits 31:26 hold year offset.
// - Year low bits zero means leap year.
// - Bits 25:22 hold month 1 to 12.
// - Bits 21:17 hold day, month-length aware.
// - 24-hour form: hour counts 0 to 23.
// - 12-hour form: 1-12 with afternoon bit.
// - Bits 11:6 hold minutes 0 to 59.
// - Bits 5:0 hold seconds, roll into minutes.
// - Single layout: 32-bit match value at 0x18.
// - Match sets equal flag, optionally zeroes count.
// - Pending bit spans each domain transfer.
package rtc_values_pkg;
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_FLAGS        = 8'h04;
  localparam logic [7:0]  ADDR_STATUS       = 8'h08;
  localparam logic [7:0]  ADDR_TRIM         = 8'h0c;
  localparam logic [7:0]  ADDR_COUNT        = 8'h10;
  localparam logic [7:0]  ADDR_WRAP         = 8'h14;
  localparam logic [7:0]  ADDR_MATCH        = 8'h18;
  localparam logic [1:0]  SINGLE_LAYOUT     = 2'h0;
  localparam logic [1:0]  PERIOD_LAYOUT     = 2'h1;
  localparam logic [1:0]  CALENDAR_LAYOUT   = 2'h2;
  localparam int          CTRL_LAYOUT_LSB   = 0;
  localparam int          CTRL_ENABLE_BIT   = 2;
  localparam int          CTRL_ZERO_EQ_BIT  = 3;
  localparam int          CTRL_TWELVE_BIT   = 4;
  localparam int          CTRL_PROTECT_BIT  = 5;
  localparam logic [7:0]  CTRL_MASK         = 8'h3f;
  localparam int          FLAG_EQUAL_BIT    = 0;
  localparam int          FLAG_OVERFLOW_BIT = 7;
  localparam int          STATUS_PEND_BIT   = 7;
  localparam int          TRIM_SIGN_BIT     = 7;
  localparam int          YEAR_LSB          = 26;
  localparam int          MONTH_LSB         = 22;
  localparam int          DAY_LSB           = 17;
  localparam int          HOUR_LSB          = 12;
  localparam int          MINUTE_LSB        = 6;
  localparam int          SECOND_LSB        = 0;
  localparam logic [5:0]  SIXTY_MAX         = 6'h3b;
  localparam logic [4:0]  HOUR24_MAX        = 5'h17;
  localparam logic [3:0]  HOUR12_MAX        = 4'hc;
  localparam logic [3:0]  HOUR12_LAST_AM    = 4'hb;
  localparam logic [3:0]  MONTH_MAX         = 4'hc;
  localparam logic [5:0]  YEAR_MAX          = 6'h3f;
  localparam logic [31:0] COUNT_RESET       = 32'h00000000;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          SYNC_TIME_NS      = 300;
  localparam int          SYNC_CYCLES       = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TICK_TIME_NS      = 800;
  localparam int          PRESCALE_DIV      = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== src/rtc_tick_gen.sv ====
// Prescaler that makes the counting tick, with signed fractional trim.
// Assumes trim is stable between bus writes and DIV is at least 2.
`timescale 1ns/1ps
module rtc_tick_gen #(
  parameter int DIV = rtc_values_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Trim setting and tick
  input  wire logic [7:0] trim,
  output logic            tick
);
  typedef struct packed {
    logic [7:0] phase;
    logic [6:0] acc;
    logic [7:0] len;
    logic       tick;
  } tick_state_type;
  localparam logic [7:0] DIV_B = 8'(DIV);
  tick_state_type s_q;
  tick_state_type s_d;
  logic [7:0]     sum;

  // The trim magnitude accumulates each tick; a carry stretches or shrinks one period.
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, trim[6:0]};
    s_d.tick = 1'b0;
    if (s_q.phase == 8'h00) begin
      s_d.tick = 1'b1;
      s_d.acc = sum[6:0];
      if (sum[7]) begin
        s_d.len = trim[rtc_values_pkg::TRIM_SIGN_BIT] ? DIV_B + 8'h01 : DIV_B - 8'h01;
      end else begin
        s_d.len = DIV_B;
      end
      s_d.phase = s_d.len - 8'h01;
    end else begin
      s_d.phase = s_q.phase - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_trim_zero_len: assert property ((s_q.phase == 8'h00 && trim[6:0] == 7'h00) |=> s_q.len == DIV_B)
    else $error("Zero trim changed the tick period.");
  a_trim_speed_up: assert property ((s_q.phase == 8'h00 && sum[7] && !trim[7]) |=> s_q.len == DIV_B - 8'h01)
    else $error("Positive trim did not shorten the period.");
  a_trim_slow_down: assert property ((s_q.phase == 8'h00 && sum[7] && trim[7]) |=> s_q.len == DIV_B + 8'h01)
    else $error("Negative trim did not lengthen the period.");
  a_tick_single: assert property (tick |=> !tick)
    else $error("Tick lasted more than one cycle.");
endmodule

// ==== src/rtc_calendar_step.sv ====
// Combinational one-second step of the packed calendar word.
// Assumes the current word holds legal field values.
`timescale 1ns/1ps
module rtc_calendar_step (
  // Current word and format
  input  wire logic [31:0] cur,
  input  wire logic        twelve,
  // Next word
  output logic [31:0]      nxt,
  output logic             year_wrap
);
  logic [5:0] yr;
  logic [3:0] mo;
  logic [4:0] dy;
  logic [4:0] hr;
  logic [5:0] mi;
  logic [5:0] se;
  logic [4:0] last_day;
  logic       day_carry;

  always_comb begin
    yr = cur[rtc_values_pkg::YEAR_LSB +: 6];
    mo = cur[rtc_values_pkg::MONTH_LSB +: 4];
    dy = cur[rtc_values_pkg::DAY_LSB +: 5];
    hr = cur[rtc_values_pkg::HOUR_LSB +: 5];
    mi = cur[rtc_values_pkg::MINUTE_LSB +: 6];
    se = cur[rtc_values_pkg::SECOND_LSB +: 6];
    day_carry = 1'b0;
    year_wrap = 1'b0;
    case (mo)
      4'h2:                last_day = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: last_day = 5'h1e;
      default:             last_day = 5'h1f;
    endcase
    if (se != rtc_values_pkg::SIXTY_MAX) begin
      se = se + 6'h01;
    end else begin
      se = 6'h00;
      if (mi != rtc_values_pkg::SIXTY_MAX) begin
        mi = mi + 6'h01;
      end else begin
        mi = 6'h00;
        if (!twelve) begin
          if (hr >= rtc_values_pkg::HOUR24_MAX) begin
            hr = 5'h00;
            day_carry = 1'b1;
          end else begin
            hr = hr + 5'h01;
          end
        end else if (hr[3:0] == rtc_values_pkg::HOUR12_LAST_AM) begin
          day_carry = hr[4];
          hr = {~hr[4], rtc_values_pkg::HOUR12_MAX};
        end else if (hr[3:0] >= rtc_values_pkg::HOUR12_MAX) begin
          hr = {hr[4], 4'h1};
        end else begin
          hr = hr + 5'h01;
        end
      end
    end
    if (day_carry) begin
      if (dy < last_day) begin
        dy = dy + 5'h01;
      end else begin
        dy = 5'h01;
        if (mo < rtc_values_pkg::MONTH_MAX) begin
          mo = mo + 4'h1;
        end else begin
          mo = 4'h1;
          year_wrap = (yr == rtc_values_pkg::YEAR_MAX);
          yr = yr + 6'h01;
        end
      end
    end
    nxt = {yr, mo, dy, hr, mi, se};
  end
endmodule

// ==== src/rtc_values.sv ====
// Counter, period and calendar value registers behind an APB slave.
// Assumes an APB master with 32-bit data and a free-running pclk.
`timescale 1ns/1ps
module rtc_values #(
  parameter int SYNC_CYCLES  = rtc_values_pkg::SYNC_CYCLES,
  parameter int PRESCALE_DIV = rtc_values_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic {
    sync_idle,
    sync_busy
  } sync_state_type;

  typedef struct packed {
    logic [7:0]     ctrl;
    logic [7:0]     trim;
    logic [31:0]    count;
    logic [31:0]    count_copy;
    logic [15:0]    wrap;
    logic [31:0]    match;
    logic [7:0]     flags;
    sync_state_type sync;
    logic [3:0]     sync_cnt;
    logic [7:0]     hold_addr;
    logic [31:0]    hold_data;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
  } state_type;

  localparam logic [3:0] SYNC_LAST = 4'(SYNC_CYCLES - 1);

  state_type   s_q;
  state_type   s_d;
  logic        tick;
  logic [31:0] cal_next;
  logic        cal_wrap;
  logic        access;
  logic        value_addr;
  logic        mapped;
  logic        accepted;
  logic        count_applied;
  logic        counting;
  logic [1:0]  layout;
  logic [7:0]  flag_clr;
  logic [7:0]  flag_set;
  logic [31:0] rd;

  rtc_tick_gen #(
    .DIV (PRESCALE_DIV)
  ) rtc_tick_gen_i (
    .pclk    (pclk),
    .presetn (presetn),
    .trim    (s_q.trim),
    .tick    (tick)
  );

  rtc_calendar_step rtc_calendar_step_i (
    .cur       (s_q.count),
    .twelve    (s_q.ctrl[rtc_values_pkg::CTRL_TWELVE_BIT]),
    .nxt       (cal_next),
    .year_wrap (cal_wrap)
  );

  always_comb begin
    s_d = s_q;
    layout = s_q.ctrl[rtc_values_pkg::CTRL_LAYOUT_LSB +: 2];
    access = psel && penable && !s_q.pready;
    value_addr = (paddr == rtc_values_pkg::ADDR_TRIM) || (paddr == rtc_values_pkg::ADDR_COUNT) ||
                 (paddr == rtc_values_pkg::ADDR_WRAP) || (paddr == rtc_values_pkg::ADDR_MATCH);
    mapped = value_addr || (paddr == rtc_values_pkg::ADDR_CTRL) ||
             (paddr == rtc_values_pkg::ADDR_FLAGS) || (paddr == rtc_values_pkg::ADDR_STATUS);
    accepted = access && pwrite && value_addr && !s_q.ctrl[rtc_values_pkg::CTRL_PROTECT_BIT] &&
               (s_q.sync == sync_idle);
    count_applied = 1'b0;
    flag_clr = 8'h00;
    flag_set = 8'h00;
    rd = 32'h00000000;
    s_d.pready = access;
    s_d.pslverr = access && !mapped;
    // The read copy lags the live count by one cycle, so reads never see a half-updated word.
    s_d.count_copy = s_q.count;

    case (paddr)
      rtc_values_pkg::ADDR_CTRL:   rd[7:0] = s_q.ctrl;
      rtc_values_pkg::ADDR_FLAGS:  rd[7:0] = s_q.flags;
      rtc_values_pkg::ADDR_STATUS: rd[rtc_values_pkg::STATUS_PEND_BIT] = (s_q.sync == sync_busy);
      rtc_values_pkg::ADDR_TRIM:   rd[7:0] = s_q.trim;
      rtc_values_pkg::ADDR_COUNT: begin
        if (layout == rtc_values_pkg::PERIOD_LAYOUT) begin
          rd[15:0] = s_q.count_copy[15:0];
        end else begin
          rd = s_q.count_copy;
        end
      end
      rtc_values_pkg::ADDR_WRAP:   rd[15:0] = s_q.wrap;
      rtc_values_pkg::ADDR_MATCH:  rd = s_q.match;
      default:                     rd = 32'h00000000;
    endcase
    if (access && !pwrite) begin
      s_d.prdata = rd;
    end

    if (access && pwrite) begin
      if (paddr == rtc_values_pkg::ADDR_CTRL) begin
        s_d.ctrl = pwdata[7:0] & rtc_values_pkg::CTRL_MASK;
      end
      if (paddr == rtc_values_pkg::ADDR_FLAGS) begin
        flag_clr = pwdata[7:0];
      end
    end
    if (accepted) begin
      s_d.hold_addr = paddr;
      s_d.hold_data = pwdata;
      s_d.sync = sync_busy;
      s_d.sync_cnt = 4'h0;
    end

    // A staged value lands in the counting logic once the transfer delay has run out.
    if (s_q.sync == sync_busy) begin
      if (s_q.sync_cnt == SYNC_LAST) begin
        s_d.sync = sync_idle;
        unique case (s_q.hold_addr)
          rtc_values_pkg::ADDR_TRIM:  s_d.trim = s_q.hold_data[7:0];
          rtc_values_pkg::ADDR_WRAP:  s_d.wrap = s_q.hold_data[15:0];
          rtc_values_pkg::ADDR_MATCH: s_d.match = s_q.hold_data;
          rtc_values_pkg::ADDR_COUNT: begin
            count_applied = 1'b1;
            if (layout == rtc_values_pkg::PERIOD_LAYOUT) begin
              s_d.count = {16'h0000, s_q.hold_data[15:0]};
            end else begin
              s_d.count = s_q.hold_data;
            end
          end
          default: s_d.sync = sync_idle;
        endcase
      end else begin
        s_d.sync_cnt = s_q.sync_cnt + 4'h1;
      end
    end

    counting = tick && s_q.ctrl[rtc_values_pkg::CTRL_ENABLE_BIT] && !count_applied;
    if (counting) begin
      case (layout)
        rtc_values_pkg::SINGLE_LAYOUT: begin
          if (s_q.count == s_q.match) begin
            flag_set[rtc_values_pkg::FLAG_EQUAL_BIT] = 1'b1;
          end
          if (s_q.count == s_q.match && s_q.ctrl[rtc_values_pkg::CTRL_ZERO_EQ_BIT]) begin
            s_d.count = rtc_values_pkg::COUNT_RESET;
          end else begin
            s_d.count = s_q.count + 32'h00000001;
            flag_set[rtc_values_pkg::FLAG_OVERFLOW_BIT] = (s_q.count == 32'hffffffff);
          end
        end
        rtc_values_pkg::PERIOD_LAYOUT: begin
          if (s_q.count[15:0] == s_q.wrap) begin
            s_d.count = rtc_values_pkg::COUNT_RESET;
            flag_set[rtc_values_pkg::FLAG_OVERFLOW_BIT] = 1'b1;
          end else begin
            s_d.count = {16'h0000, s_q.count[15:0] + 16'h0001};
          end
        end
        rtc_values_pkg::CALENDAR_LAYOUT: begin
          s_d.count = cal_next;
          flag_set[rtc_values_pkg::FLAG_OVERFLOW_BIT] = cal_wrap;
        end
        default: s_d.count = s_q.count;
      endcase
    end
    // A flag raised in the cycle software clears it stays raised.
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_busy_run;
    (s_q.sync == sync_busy) [*3] ##1 (s_q.sync == sync_idle);
  endsequence
  sequence s_plain_tick;
    counting && (s_q.sync == sync_idle);
  endsequence
  sequence s_landing;
    (s_q.sync == sync_busy) && (s_q.sync_cnt == SYNC_LAST);
  endsequence

  a_sync_window: assert property (accepted |=> s_busy_run)
    else $error("Transfer pending bit did not span the sync delay.");
  a_protect_block: assert property ((access && pwrite && value_addr && (s_q.sync == sync_idle) &&
    s_q.ctrl[rtc_values_pkg::CTRL_PROTECT_BIT]) |=> (s_q.sync == sync_idle))
    else $error("Protected write started a transfer.");
  a_pend_block: assert property ((access && pwrite && value_addr && (s_q.sync == sync_busy)) |=>
    $stable(s_q.hold_data))
    else $error("Write during a pending transfer was staged.");
  a_pend_status: assert property ((access && !pwrite && paddr == rtc_values_pkg::ADDR_STATUS) |=>
    prdata[rtc_values_pkg::STATUS_PEND_BIT] == ($past(s_q.sync) == sync_busy))
    else $error("Status read did not show the pending bit.");
  a_wrap_land: assert property ((s_landing ##0 (s_q.hold_addr == rtc_values_pkg::ADDR_WRAP)) |=>
    s_q.wrap == s_q.hold_data[15:0])
    else $error("Staged wrap limit did not land.");
  a_match_land: assert property ((s_landing ##0 (s_q.hold_addr == rtc_values_pkg::ADDR_MATCH)) |=>
    s_q.match == s_q.hold_data)
    else $error("Staged match value did not land.");
  a_count_land: assert property ((s_landing ##0 (s_q.hold_addr == rtc_values_pkg::ADDR_COUNT &&
    layout == rtc_values_pkg::SINGLE_LAYOUT)) |=> s_q.count == s_q.hold_data)
    else $error("Staged count did not land.");
  a_read_copy: assert property ((access && !pwrite && paddr == rtc_values_pkg::ADDR_COUNT &&
    layout == rtc_values_pkg::SINGLE_LAYOUT) |=> prdata == $past(s_q.count, 2))
    else $error("Count read did not return the synchronized copy.");
  a_count_step: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::SINGLE_LAYOUT &&
    s_q.count != s_q.match)) |=> s_q.count == $past(s_q.count) + 32'h00000001)
    else $error("Single counter did not advance by one.");
  a_equal_flag: assert property ((counting && layout == rtc_values_pkg::SINGLE_LAYOUT &&
    s_q.count == s_q.match) |=> s_q.flags[rtc_values_pkg::FLAG_EQUAL_BIT])
    else $error("Equal flag not set after match.");
  a_zero_on_equal: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::SINGLE_LAYOUT &&
    s_q.count == s_q.match && s_q.ctrl[rtc_values_pkg::CTRL_ZERO_EQ_BIT])) |=> s_q.count == 32'h00000000)
    else $error("Count not zeroed on match.");
  a_period_wrap: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::PERIOD_LAYOUT &&
    s_q.count[15:0] == s_q.wrap)) |=> s_q.count == 32'h00000000 && s_q.flags[rtc_values_pkg::FLAG_OVERFLOW_BIT])
    else $error("Period counter did not wrap at the limit.");
  a_period_read: assert property ((access && !pwrite && paddr == rtc_values_pkg::ADDR_COUNT &&
    layout == rtc_values_pkg::PERIOD_LAYOUT) |=> pready && prdata[31:16] == 16'h0000)
    else $error("Period count read showed upper bits.");
  a_second_roll: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::CALENDAR_LAYOUT &&
    s_q.count[5:0] == 6'h3b)) |=> s_q.count[5:0] == 6'h00 && s_q.count[11:6] != $past(s_q.count[11:6]))
    else $error("Seconds did not roll into minutes.");
  a_hour_24: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::CALENDAR_LAYOUT &&
    !s_q.ctrl[rtc_values_pkg::CTRL_TWELVE_BIT] && s_q.count[16:0] == 17'h17efb)) |=> s_q.count[16:12] == 5'h00)
    else $error("Hour did not wrap after 23.");
  a_hour_12: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::CALENDAR_LAYOUT &&
    s_q.ctrl[rtc_values_pkg::CTRL_TWELVE_BIT] && s_q.count[16:0] == 17'h1befb)) |=> s_q.count[16:12] == 5'h0c)
    else $error("Afternoon eleven did not roll to morning twelve.");
  a_leap_feb: assert property ((s_plain_tick ##0 (layout == rtc_values_pkg::CALENDAR_LAYOUT &&
    !s_q.ctrl[rtc_values_pkg::CTRL_TWELVE_BIT] && s_q.count[27:0] == 28'h0b97efb)) |=> s_q.count[21:17] == 5'h1d)
    else $error("Leap-year February ended at day 28.");
endmodule

// ==== verification/tb_rtc_values.sv ====
// Self-checking testbench for the counter, period and calendar value block.
// Assumes an APB slave that raises pready after a wait state; drives APB by hand.
`timescale 1ns/1ps
module tb_rtc_values;
  localparam int DIV = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          error_cnt;
  int          checks_done;

  rtc_values #(.SYNC_CYCLES(3), .PRESCALE_DIV(DIV)) rtc_values_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #50 pclk = ~pclk;

  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer; the request is left up so a setup cycle may follow at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask

  task automatic release_bus();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    release_bus();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(r, exp);
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      rd(rtc_values_pkg::ADDR_STATUS, s);
      n++;
    end while (s[rtc_values_pkg::STATUS_PEND_BIT] !== 1'b0 && n < 20);
    check(s, 32'h0);
  endtask

  task automatic wr_val(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    wait_idle();
  endtask

  // Control word: protect, twelve-hour, zero on equal, enable, layout.
  function automatic logic [31:0] ctl(input logic [1:0] lay, input logic en, input logic zr, input logic tw,
                                      input logic pr);
    ctl = {26'h0, pr, tw, zr, en, lay};
  endfunction

  function automatic logic [31:0] cal(input int y, input int mo, input int d, input int h, input int mi,
                                      input int s);
    cal = {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd_chk(rtc_values_pkg::ADDR_COUNT, 32'h0);
    rd_chk(rtc_values_pkg::ADDR_WRAP, 32'h0);
    rd_chk(rtc_values_pkg::ADDR_MATCH, 32'h0);
    rd_chk(rtc_values_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, 8'h24, 32'h5, r, e);
    release_bus();
    check({31'h0, e}, 32'h1);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b1, rtc_values_pkg::ADDR_MATCH, 32'hdeadbeef, r, e);
    apb(1'b0, rtc_values_pkg::ADDR_STATUS, 32'h0, r, e);
    release_bus();
    check(r, 32'h80);
    wait_idle();
    rd_chk(rtc_values_pkg::ADDR_MATCH, 32'hdeadbeef);
    wr_val(rtc_values_pkg::ADDR_WRAP, 32'h0001abcd);
    rd_chk(rtc_values_pkg::ADDR_WRAP, 32'h0000abcd);
    wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    wr_val(rtc_values_pkg::ADDR_MATCH, 32'h1);
    wr_val(rtc_values_pkg::ADDR_COUNT, 32'h77);
    rd_chk(rtc_values_pkg::ADDR_MATCH, 32'hdeadbeef);
    rd_chk(rtc_values_pkg::ADDR_COUNT, 32'h0);
    wr(rtc_values_pkg::ADDR_CTRL, 32'h0);
  endtask

  task automatic t_match();
    logic [31:0] r;
    logic [31:0] c;
    wr_val(rtc_values_pkg::ADDR_MATCH, 32'h3);
    wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h0, 1'b1, 1'b1, 1'b0, 1'b0));
    repeat (25 * DIV) @(posedge pclk);
    rd(rtc_values_pkg::ADDR_FLAGS, r);
    check({31'h0, r[rtc_values_pkg::FLAG_EQUAL_BIT]}, 32'h1);
    rd(rtc_values_pkg::ADDR_COUNT, r);
    check({31'h0, r <= 32'h3}, 32'h1);
    wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h3, 1'b1, 1'b0, 1'b0, 1'b0));
    rd(rtc_values_pkg::ADDR_COUNT, c);
    repeat (4 * DIV) @(posedge pclk);
    rd_chk(rtc_values_pkg::ADDR_COUNT, c);
    wr(rtc_values_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_values_pkg::ADDR_FLAGS, 32'h1);
    rd(rtc_values_pkg::ADDR_FLAGS, r);
    check({31'h0, r[rtc_values_pkg::FLAG_EQUAL_BIT]}, 32'h0);
  endtask

  task automatic t_period();
    logic [31:0] r;
    wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h1, 1'b0, 1'b0, 1'b0, 1'b0));
    wr_val(rtc_values_pkg::ADDR_COUNT, 32'habcd1234);
    rd_chk(rtc_values_pkg::ADDR_COUNT, 32'h00001234);
    wr_val(rtc_values_pkg::ADDR_WRAP, 32'h4);
    wr_val(rtc_values_pkg::ADDR_COUNT, 32'h0);
    wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h1, 1'b1, 1'b0, 1'b0, 1'b0));
    repeat (25 * DIV) @(posedge pclk);
    rd(rtc_values_pkg::ADDR_COUNT, r);
    check({31'h0, r <= 32'h4}, 32'h1);
    rd(rtc_values_pkg::ADDR_FLAGS, r);
    check({31'h0, r[rtc_values_pkg::FLAG_OVERFLOW_BIT]}, 32'h1);
    wr(rtc_values_pkg::ADDR_CTRL, 32'h0);
  endtask

  // Ticks counted over 90 nominal periods: 90 untrimmed, near 103 sped up, near 80 slowed.
  task automatic t_trim();
    logic [7:0]  tv [3] = '{8'h00, 8'h7f, 8'hff};
    int          lo [3] = '{87, 99, 77};
    int          hi [3] = '{93, 106, 83};
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      wr_val(rtc_values_pkg::ADDR_TRIM, {24'h0, tv[i]});
      rd_chk(rtc_values_pkg::ADDR_TRIM, {24'h0, tv[i]});
      wr_val(rtc_values_pkg::ADDR_COUNT, 32'h0);
      wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h0, 1'b1, 1'b0, 1'b0, 1'b0));
      repeat (90 * DIV) @(posedge pclk);
      wr(rtc_values_pkg::ADDR_CTRL, 32'h0);
      rd(rtc_values_pkg::ADDR_COUNT, r);
      check({31'h0, r >= lo[i] && r <= hi[i]}, 32'h1);
    end
    wr_val(rtc_values_pkg::ADDR_TRIM, 32'h0);
  endtask

  // Only legal field values are written.
  task automatic t_calendar();
    logic [31:0] st [8];
    logic [31:0] ex [8];
    logic        tw [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [31:0] r;
    int          n;
    st = '{cal(4, 2, 28, 23, 59, 59), cal(5, 2, 28, 23, 59, 59), cal(3, 12, 31, 23, 59, 59),
           cal(1, 4, 30, 23, 59, 59), cal(1, 4, 10, 10, 59, 59), cal(2, 6, 5, 11, 59, 59),
           cal(2, 1, 5, 27, 59, 59), cal(2, 6, 5, 28, 59, 59)};
    ex = '{cal(4, 2, 29, 0, 0, 0), cal(5, 3, 1, 0, 0, 0), cal(4, 1, 1, 0, 0, 0),
           cal(1, 5, 1, 0, 0, 0), cal(1, 4, 10, 11, 0, 0), cal(2, 6, 5, 28, 0, 0),
           cal(2, 1, 6, 12, 0, 0), cal(2, 6, 5, 17, 0, 0)};
    for (int i = 0; i < 8; i++) begin
      wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h2, 1'b0, 1'b0, tw[i], 1'b0));
      wr_val(rtc_values_pkg::ADDR_COUNT, st[i]);
      rd_chk(rtc_values_pkg::ADDR_COUNT, st[i]);
      wr(rtc_values_pkg::ADDR_CTRL, ctl(2'h2, 1'b1, 1'b0, tw[i], 1'b0));
      n = 0;
      do begin
        rd(rtc_values_pkg::ADDR_COUNT, r);
        n++;
      end while (r === st[i] && n < 10);
      wr(rtc_values_pkg::ADDR_CTRL, 32'h0);
      check(r, ex[i]);
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_match();
    t_period();
    t_trim();
    t_calendar();
    finish_test();
  end

  initial begin
    #(20000 * 100);
    error_cnt++;
    finish_test();
  end
endmodule
